// file: dv/pin_model.sv
// Pins with external drivers and pull-ups
`timescale 1ns/10ps
module pin_model (
    // Stage enables and outside drive
    input wire logic [31:0] oe_n_i,
    input wire logic [31:0] drv_i,
    // Pin levels
    output logic [31:0] pin_o
);
    // Pull-down beats any outside high; port zero leans on a board pull-up
    assign pin_o = oe_n_i & drv_i;
endmodule // pin_model

// file: dv/quasi_bidir_port_logic_checker.sv
// Checker for phase, latch, stage and bus relations of the port block
`timescale 1ns/10ps
module quasi_bidir_port_logic_checker #(
    parameter int PORT_W = 8
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Core side
    input wire port_pkg::port_wr_s wr_i,
    input wire logic [1:0] rd_port_i,
    input wire logic rd_latch_i,
    input wire logic [PORT_W-1:0] rd_data_o,
    input wire logic [3:0] phase_o,
    input wire port_pkg::ext_bus_s bus_i,
    input wire port_pkg::alt_in_s alt_o,
    // Pin enables
    input wire logic [PORT_W-1:0] port_zero_oe_n_o,
    input wire logic [PORT_W-1:0] port_one_oe_n_o,
    input wire logic [PORT_W-1:0] port_two_oe_n_o,
    input wire logic [PORT_W-1:0] port_three_oe_n_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_take; phase_o == 4'hc && wr_i.we && wr_i.port == 2'h1; endsequence
    sequence s_busrd; bus_i.active ##1 bus_i.active && rd_latch_i && rd_port_i == 2'h0; endsequence
    property p_wrap; phase_o == 4'hc |=> phase_o == 4'h1; endproperty
    a_wrap: assert property (p_wrap) else $error("phase wrap");
    property p_write; s_take |-> ##2 port_one_oe_n_o == $past(wr_i.data, 2); endproperty
    a_write: assert property (p_write) else $error("write to pin");
    property p_drive; $changed(port_one_oe_n_o) |-> phase_o == 4'h2; endproperty
    a_drive: assert property (p_drive) else $error("stage moved off phase");
    property p_rmw; rd_latch_i && rd_port_i == 2'h1 && phase_o inside {[4'h2:4'hb]}
        |=> rd_data_o == port_one_oe_n_o; endproperty
    a_rmw: assert property (p_rmw) else $error("latch read");
    property p_busrd; s_busrd |=> rd_data_o == 8'hff; endproperty
    a_busrd: assert property (p_busrd) else $error("bus latch not ones");
    property p_lo; bus_i.active && bus_i.addr_phase |-> port_zero_oe_n_o == bus_i.addr_lo; endproperty
    a_lo: assert property (p_lo) else $error("low address");
    property p_hi; bus_i.active |-> port_two_oe_n_o == bus_i.addr_hi; endproperty
    a_hi: assert property (p_hi) else $error("high address");
    property p_wr; bus_i.active && !bus_i.wr_n |-> !port_three_oe_n_o[6]; endproperty
    a_wr: assert property (p_wr) else $error("write strobe");
    property p_slo; $changed(alt_o.timer2_count_in) |-> phase_o == 4'ha; endproperty
    a_slo: assert property (p_slo) else $error("low sample phase");
    property p_shi; $changed(alt_o.timer0_count_in) |-> phase_o == 4'hb; endproperty
    a_shi: assert property (p_shi) else $error("high sample phase");
endmodule // quasi_bidir_port_logic_checker

// file: dv/quasi_bidir_port_logic_test.sv
// Self-checking bench for the port pin block
`timescale 1ns/10ps
module quasi_bidir_port_logic_test;
    logic sys_clk_i = 0;
    logic reset_n_i = 0;
    port_pkg::port_wr_s wr_i = '0;
    logic [1:0] rd_port_i = 0;
    logic rd_latch_i = 0;
    port_pkg::ext_bus_s bus_i = 29'h3;
    port_pkg::p3_alt_out_s p3_alt_i = 3'h4;
    logic [7:0] pull;
    logic [31:0] drv = '1;
    logic [31:0] oe_n;
    logic [31:0] pin;
    logic [7:0] rd_data_o;
    logic [3:0] phase_o;
    port_pkg::alt_in_s alt_o;
    int n_mismatch = 0;
    int compares = 0;
    quasi_bidir_port_logic DUT (.sys_clk_i, .reset_n_i, .wr_i, .rd_port_i, .rd_latch_i, .rd_data_o,
        .phase_o, .bus_i, .p3_alt_i, .alt_o, .bus_rdata_o(), .port_zero_i(pin[7:0]), .port_one_i(pin[15:8]),
        .port_two_i(pin[23:16]), .port_three_i(pin[31:24]), .port_zero_o(), .port_one_o(), .port_two_o(),
        .port_three_o(), .port_zero_oe_n_o(oe_n[7:0]), .port_one_oe_n_o(oe_n[15:8]),
        .port_two_oe_n_o(oe_n[23:16]), .port_three_oe_n_o(oe_n[31:24]), .pullup_strong_o(pull));
    pin_model pins (.oe_n_i(oe_n), .drv_i(drv), .pin_o(pin));
    initial forever #10 sys_clk_i = ~sys_clk_i;
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic at_ph(input logic [3:0] p);
        do @(negedge sys_clk_i); while (phase_o !== p);
    endtask
    task automatic wr(input logic [1:0] p, input logic [7:0] d);
        at_ph(4'hc);
        wr_i = {1'b1, p, d};
        @(negedge sys_clk_i);
        wr_i.we = 0;
    endtask
    task automatic rd(input logic [1:0] p, input logic l, input logic [7:0] exp);
        rd_port_i = p;
        rd_latch_i = l;
        @(negedge sys_clk_i);
        chk("rd_data", rd_data_o, exp);
    endtask
    task automatic t_reset;
        for (int p = 0; p < 4; p++) rd(p[1:0], 1, 8'hff);
        chk("oe_n", oe_n[7:0] & oe_n[15:8] & oe_n[23:16] & oe_n[31:24], 8'hff);
        $display("test reset done");
    endtask
    task automatic t_write;
        wr(1, 8'h5a);
        chk("oe_n one", oe_n[15:8], 8'hff);
        rd(1, 1, 8'h5a);
        chk("oe_n one", oe_n[15:8], 8'h5a);
        at_ph(4'hb);
        rd(1, 0, 8'h5a);
        at_ph(4'h5);
        wr_i = {1'b1, 2'h1, 8'h00};
        @(negedge sys_clk_i);
        wr_i.we = 0;
        at_ph(4'h6);
        rd(1, 1, 8'h5a);
        wr(1, 8'hff);
        $display("test write done");
    endtask
    task automatic t_pin;
        drv[15:8] = 8'ha6;
        drv[31:24] = 8'h25;
        repeat (26) @(negedge sys_clk_i);
        rd(1, 0, 8'ha6);
        rd(1, 1, 8'hff);
        rd(3, 0, 8'h25);
        chk("t2", {6'h0, alt_o.timer2_aux_in, alt_o.timer2_count_in}, 8'h2);
        chk("alt3", {3'h0, alt_o.timer1_count_in, alt_o.timer0_count_in, alt_o.ext_irq_one,
            alt_o.ext_irq_zero, alt_o.rxd}, 8'h13);
        wr(3, 8'hdf);
        repeat (26) @(negedge sys_clk_i);
        chk("pin3", pin[31:24], 8'h05);
        chk("t1", {7'h0, alt_o.timer1_count_in}, 8'h0);
        wr(3, 8'hff);
        drv = '1;
        $display("test pins done");
    endtask
    task automatic t_bus;
        wr(0, 8'h00);
        wr(2, 8'h3c);
        @(negedge sys_clk_i);
        chk("oe_n zero", oe_n[7:0], 8'h00);
        bus_i = {2'h3, 8'h96, 8'h71, 8'h00, 3'h1};
        @(negedge sys_clk_i);
        chk("lo", oe_n[7:0], 8'h96);
        chk("hi", oe_n[23:16], 8'h71);
        chk("pullup", pull, 8'h96);
        chk("wr strobe", {7'h0, oe_n[30]}, 8'h0);
        rd(0, 1, 8'hff);
        rd(2, 1, 8'h3c);
        bus_i = 29'h3;
        repeat (26) @(negedge sys_clk_i);
        chk("oe_n zero", oe_n[7:0], 8'hff);
        chk("pullup idle", pull, 8'h00);
        $display("test bus done");
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge sys_clk_i);
        @(negedge sys_clk_i) reset_n_i = 1;
        t_reset();
        t_write();
        t_pin();
        t_bus();
        end_sim();
    end
    initial begin
        #100000;
        n_mismatch++;
        end_sim();
    end
endmodule // quasi_bidir_port_logic_test
bind quasi_bidir_port_logic quasi_bidir_port_logic_checker #(.PORT_W(PORT_W)) chk_u (.sys_clk_i, .reset_n_i,
    .wr_i, .rd_port_i, .rd_latch_i, .rd_data_o, .phase_o, .bus_i, .alt_o, .port_zero_oe_n_o,
    .port_one_oe_n_o, .port_two_oe_n_o, .port_three_oe_n_o);

// file: logic/port_pkg.sv
// Package of constants and carrier types for the four-port pin block
package port_pkg;
    localparam int PORT_W = 8;
    localparam int PHASES = 12;
    localparam logic [7:0] LATCH_RST = 8'hff;
    // Machine cycle phase numbers (1..12)
    localparam logic [3:0] PH_WRITE = 4'hc;
    localparam logic [3:0] PH_DRIVE = 4'h1;
    localparam logic [3:0] PH_SAMP_LO = 4'h9;
    localparam logic [3:0] PH_SAMP_HI = 4'ha;
    // Port three bit positions
    localparam int P3_RXD = 0;
    localparam int P3_TXD = 1;
    localparam int P3_IRQ0 = 2;
    localparam int P3_IRQ1 = 3;
    localparam int P3_T0 = 4;
    localparam int P3_T1 = 5;
    localparam int P3_WR = 6;
    localparam int P3_RD = 7;
    // Port one bit positions
    localparam int P1_T2 = 0;
    localparam int P1_TIMER2_AUX_IN = 1;
    // Core write request to one port
    typedef struct packed {
        logic we;
        logic [1:0] port;
        logic [7:0] data;
    } port_wr_s;
    // External bus drive from the core
    typedef struct packed {
        logic active;
        logic addr_phase;
        logic [7:0] addr_lo;
        logic [7:0] addr_hi;
        logic [7:0] wdata;
        logic wdata_oe;
        logic wr_n;
        logic rd_n;
    } ext_bus_s;
    // Alternate functions driven onto port three
    typedef struct packed {
        logic txd;
        logic rxd_out;
        logic rxd_oe;
    } p3_alt_out_s;
    // Alternate inputs handed to peripherals
    typedef struct packed {
        logic rxd;
        logic ext_irq_zero;
        logic ext_irq_one;
        logic timer0_count_in;
        logic timer1_count_in;
        logic timer2_count_in;
        logic timer2_aux_in;
    } alt_in_s;
endpackage

// file: logic/quasi_bidir_port_logic.sv
// Four 8-bit port latches, pin output stages and pin samplers
//
// What this block does
// - Port zero pins driven from latch or multiplexed address/data bus during external access.
// - Port two pins driven from latch or upper address byte during external access.
// - During external access port zero and two latches are cut off from the pins; port zero latch set all ones.
// - Port one bit 0 feeds timer two count, bit 1 its auxiliary input.
// - Port three alternate function works only while its latch bit is one.
// - Port three bit 0 is serial receive/data, bit 1 transmit/shift clock.
// - Port three bits 2,3 external interrupts and gates; bits 4,5 timer counts.
// - Port three bits 6,7 carry external write and read strobes.
// - Read-modify-write instructions read the latch, not the pins.
// - Other port reads return the sampled pin levels.
// - Latch writes take effect in phase T12 of the last machine cycle.
// - Output stage copies latch only in phase one, reaching pins next cycle.
// - Inputs sampled in T9 for ports zero, one and T10 for two, three.
// - Latch zero turns on pull-down; one releases it to the pull-up.
// - Reset loads every latch bit with one.
// - Port zero is open drain as I/O; pull-up only during bus access.
`timescale 1ns/10ps
module quasi_bidir_port_logic #(
    parameter int PORT_W = port_pkg::PORT_W
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Core write and read
    input wire port_pkg::port_wr_s wr_i,
    input wire logic [1:0] rd_port_i,
    input wire logic rd_latch_i,
    output logic [PORT_W-1:0] rd_data_o,
    output logic [3:0] phase_o,
    // External bus and alternate functions
    input wire port_pkg::ext_bus_s bus_i,
    input wire port_pkg::p3_alt_out_s p3_alt_i,
    output port_pkg::alt_in_s alt_o,
    output logic [PORT_W-1:0] bus_rdata_o,
    // Pins: output enable low means the pin is pulled low
    input wire logic [PORT_W-1:0] port_zero_i,
    input wire logic [PORT_W-1:0] port_one_i,
    input wire logic [PORT_W-1:0] port_two_i,
    input wire logic [PORT_W-1:0] port_three_i,
    output logic [PORT_W-1:0] port_zero_o,
    output logic [PORT_W-1:0] port_zero_oe_n_o,
    output logic [PORT_W-1:0] port_one_o,
    output logic [PORT_W-1:0] port_one_oe_n_o,
    output logic [PORT_W-1:0] port_two_o,
    output logic [PORT_W-1:0] port_two_oe_n_o,
    output logic [PORT_W-1:0] port_three_o,
    output logic [PORT_W-1:0] port_three_oe_n_o,
    output logic [PORT_W-1:0] pullup_strong_o
);

    // Phase counter
    logic [3:0] phase_ff;
    logic [3:0] nxt_phase;
    // Latches, output stage copies, synchronisers and samples
    logic [PORT_W-1:0] latch_ff [4];
    logic [PORT_W-1:0] nxt_latch [4];
    logic [PORT_W-1:0] stage_ff [4];
    logic [PORT_W-1:0] nxt_stage [4];
    logic [PORT_W-1:0] sync1_ff [4];
    logic [PORT_W-1:0] sync2_ff [4];
    logic [PORT_W-1:0] samp_ff [4];
    logic [PORT_W-1:0] nxt_samp [4];
    logic [PORT_W-1:0] rd_data_ff;
    logic [PORT_W-1:0] nxt_rd_data;
    logic [PORT_W-1:0] pin_in [4];
    logic [PORT_W-1:0] drv [4];
    logic [PORT_W-1:0] p0_oe_n;
    logic [PORT_W-1:0] p3_alt;
    logic [PORT_W-1:0] p3_alt_en;

    assign pin_in[0] = port_zero_i;
    assign pin_in[1] = port_one_i;
    assign pin_in[2] = port_two_i;
    assign pin_in[3] = port_three_i;

    // Phase helper shared by the stage and samplers
    function automatic logic at_phase(input logic [3:0] ph, input logic [3:0] want);
        at_phase = (ph == want);
    endfunction

    always_comb begin
        if (phase_ff == 4'(port_pkg::PHASES)) begin
            nxt_phase = 4'h1;
        end else begin
            nxt_phase = phase_ff + 4'h1;
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            nxt_latch[i] = latch_ff[i];
            nxt_stage[i] = stage_ff[i];
            nxt_samp[i] = samp_ff[i];
            // Core must assert the write only in the instruction's last cycle
            if (wr_i.we && wr_i.port == 2'(i) && at_phase(phase_ff, port_pkg::PH_WRITE)) begin
                nxt_latch[i] = wr_i.data;
            end
            if (at_phase(phase_ff, port_pkg::PH_DRIVE)) begin
                nxt_stage[i] = latch_ff[i];
            end
            // Pins held over one machine cycle are always caught by one sample
            if (at_phase(phase_ff, (i < 2) ? port_pkg::PH_SAMP_LO : port_pkg::PH_SAMP_HI)) begin
                nxt_samp[i] = sync2_ff[i];
            end
        end
        if (bus_i.active) begin
            nxt_latch[0] = port_pkg::LATCH_RST;
            nxt_stage[0] = port_pkg::LATCH_RST;
        end
    end

    always_comb begin
        if (rd_latch_i) begin
            nxt_rd_data = latch_ff[rd_port_i];
        end else begin
            nxt_rd_data = samp_ff[rd_port_i];
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            phase_ff <= 4'h1;
            rd_data_ff <= 8'h00;
            for (int i = 0; i < 4; i++) begin
                latch_ff[i] <= port_pkg::LATCH_RST;
                stage_ff[i] <= port_pkg::LATCH_RST;
                sync1_ff[i] <= 8'hff;
                sync2_ff[i] <= 8'hff;
                samp_ff[i] <= 8'hff;
            end
        end else begin
            phase_ff <= nxt_phase;
            rd_data_ff <= nxt_rd_data;
            for (int i = 0; i < 4; i++) begin
                latch_ff[i] <= nxt_latch[i];
                stage_ff[i] <= nxt_stage[i];
                sync1_ff[i] <= pin_in[i];
                sync2_ff[i] <= sync1_ff[i];
                samp_ff[i] <= nxt_samp[i];
            end
        end
    end

    // Port three alternate outputs; a zero latch still pulls the pin low
    always_comb begin
        p3_alt = 8'hff;
        p3_alt_en = 8'h00;
        p3_alt[port_pkg::P3_TXD] = p3_alt_i.txd;
        p3_alt_en[port_pkg::P3_TXD] = 1'b1;
        if (p3_alt_i.rxd_oe) begin
            p3_alt[port_pkg::P3_RXD] = p3_alt_i.rxd_out;
            p3_alt_en[port_pkg::P3_RXD] = 1'b1;
        end
        if (bus_i.active) begin
            p3_alt[port_pkg::P3_WR] = bus_i.wr_n;
            p3_alt[port_pkg::P3_RD] = bus_i.rd_n;
            p3_alt_en[port_pkg::P3_WR] = 1'b1;
            p3_alt_en[port_pkg::P3_RD] = 1'b1;
        end
    end

    always_comb begin
        drv[1] = stage_ff[1];
        drv[3] = stage_ff[3] & (p3_alt | ~p3_alt_en);
        if (bus_i.active) begin
            drv[2] = bus_i.addr_hi;
        end else begin
            drv[2] = stage_ff[2];
        end
        if (bus_i.active && bus_i.addr_phase) begin
            drv[0] = bus_i.addr_lo;
            // A one bit releases the pin, so the enable follows the address bit itself
            p0_oe_n = bus_i.addr_lo;
        end else if (bus_i.active && bus_i.wdata_oe) begin
            drv[0] = bus_i.wdata;
            p0_oe_n = bus_i.wdata;
        end else if (bus_i.active) begin
            drv[0] = 8'hff;
            p0_oe_n = 8'hff;
        end else begin
            drv[0] = stage_ff[0];
            p0_oe_n = stage_ff[0];
        end
    end

    assign port_zero_o = 8'h00;
    assign port_zero_oe_n_o = p0_oe_n;
    assign port_one_o = 8'h00;
    assign port_one_oe_n_o = drv[1];
    assign port_two_o = 8'h00;
    assign port_two_oe_n_o = drv[2];
    assign port_three_o = 8'h00;
    assign port_three_oe_n_o = drv[3];
    // Strong pull-up only for port zero while the bus drives ones
    assign pullup_strong_o = (bus_i.active && (bus_i.addr_phase || bus_i.wdata_oe)) ? drv[0] : 8'h00;

    assign rd_data_o = rd_data_ff;
    assign phase_o = phase_ff;
    assign bus_rdata_o = samp_ff[0];

    // Alternate inputs come from sampled pins
    assign alt_o.rxd = samp_ff[3][port_pkg::P3_RXD];
    assign alt_o.ext_irq_zero = samp_ff[3][port_pkg::P3_IRQ0];
    assign alt_o.ext_irq_one = samp_ff[3][port_pkg::P3_IRQ1];
    assign alt_o.timer0_count_in = samp_ff[3][port_pkg::P3_T0];
    assign alt_o.timer1_count_in = samp_ff[3][port_pkg::P3_T1];
    assign alt_o.timer2_count_in = samp_ff[1][port_pkg::P1_T2];
    assign alt_o.timer2_aux_in = samp_ff[1][port_pkg::P1_TIMER2_AUX_IN];

endmodule // quasi_bidir_port_logic
